// ===== core/eoih_pkg.sv
// Purpose: Constants for the end-of-interrupt completion handler
// Assumes: System register writes arrive as one-cycle strobes
// Notes:   Encodings and field positions shared by design and bench
package eoih_pkg;

   // -----------------------------------------------------------------
   // System register encoding
   // -----------------------------------------------------------------
   localparam logic [2:0] ENC_OP1     = 3'h0;
   localparam logic [3:0] ENC_CRN     = 4'hc;
   localparam logic [2:0] ENC_OP2     = 3'h1;
   localparam logic [3:0] ENC_CRM_G0  = 4'h8;
   localparam logic [3:0] ENC_CRM_G1  = 4'hc;

   // -----------------------------------------------------------------
   // Data layout
   // -----------------------------------------------------------------
   localparam int ID_LSB        = 0;
   localparam int ID_MSB        = 23;
   localparam int ID_NARROW_MSB = 15;
   localparam int ID_WIDE_BITS  = 24;
   localparam int ID_NARROW_BITS = 16;

   // Special identifiers that never name a real interrupt
   localparam logic [23:0] ID_SPECIAL_A = 24'h0003fc;
   localparam logic [23:0] ID_SPECIAL_B = 24'h0003fd;
   localparam logic [23:0] ID_SPECIAL_C = 24'h0003ff;

   // -----------------------------------------------------------------
   // Exception levels and reset trap level
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      EOIH_EL0 = 2'b00,
      EOIH_EL1 = 2'b01,
      EOIH_EL2 = 2'b10,
      EOIH_EL3 = 2'b11
   } eoih_level_t;

   localparam logic [1:0] RESET_LEVEL = 2'h0;

endpackage : eoih_pkg

// ===== core/eoih_handler.sv
// Purpose: Decode completion writes, select completion mode, redirect
//          to virtual registers, drop special identifiers unless redirected, and traps
// Assumes: One write strobe per cycle from the processing element
// Notes:   One-cycle latency; every output is registered
`timescale 1ns/100ps
`default_nettype none

module eoih_handler
   import eoih_pkg::*;
#(
   parameter bit MONITOR_PRESENT = 1'b1,
   parameter int ID_BITS         = 24
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_wr_valid,
   input  wire logic [2:0]  i_wr_op1,
   input  wire logic [3:0]  i_wr_crn,
   input  wire logic [3:0]  i_wr_crm,
   input  wire logic [2:0]  i_wr_op2,
   input  wire logic [31:0] i_wr_data,
   input  wire logic [1:0]  i_cur_level,
   input  wire logic        i_nonsecure_state_bit,
   input  wire logic        i_os_completion_mode,
   input  wire logic        i_monitor_completion_mode,
   input  wire logic        i_secure_os_completion_mode,
   input  wire logic        i_nonsecure_os_completion_mode,
   input  wire logic        i_hypervisor_fast_irq_routing,
   input  wire logic        i_hypervisor_normal_irq_routing,
   input  wire logic        i_os_sysreg_enable,
   input  wire logic        i_hypervisor_sysreg_enable,
   input  wire logic        i_monitor_sysreg_enable,
   input  wire logic        i_trap_all_group0,
   input  wire logic        i_trap_all_group1,
   input  wire logic        i_monitor_fast_irq_routing,
   input  wire logic        i_monitor_normal_irq_routing,
   output logic             o_prio_drop,
   output logic             o_deactivate,
   output logic             o_group1,
   output logic [23:0]      o_interrupt_identifier,
   output logic             o_virt_valid,
   output logic             o_virt_group1,
   output logic [23:0]      o_virt_identifier,
   output logic             o_trap,
   output logic [1:0]       o_trap_level,
   output logic [4:0]       o_identifier_width_field
);

   // Refuse identifier widths the datapath cannot serve
   if (ID_BITS != ID_WIDE_BITS && ID_BITS != ID_NARROW_BITS) begin : g_id_bits
      $error("ID_BITS must be 16 or 24");
   end

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic        enc_base;
   logic        hit_g0;
   logic        hit_g1;
   logic        hit;
   logic [23:0] wr_id;
   logic        is_special;
   logic        ns_os;

   assign enc_base = i_wr_op1 == ENC_OP1 && i_wr_crn == ENC_CRN
                     && i_wr_op2 == ENC_OP2;
   assign hit_g0 = i_wr_valid && enc_base
                   && i_wr_crm == ENC_CRM_G0;
   assign hit_g1 = i_wr_valid && enc_base
                   && i_wr_crm == ENC_CRM_G1;
   // Level zero writes are neither taken nor trapped
   assign hit    = (hit_g0 || hit_g1)
                   && i_cur_level != EOIH_EL0;

   // Top byte and unimplemented identifier bits are ignored
   always_comb begin
      wr_id = i_wr_data[ID_MSB:ID_LSB];
      if (ID_BITS == ID_NARROW_BITS) begin
         wr_id[ID_MSB:ID_NARROW_MSB+1] = 8'h00;
      end
   end

   assign is_special = wr_id == ID_SPECIAL_A || wr_id == ID_SPECIAL_B
                       || wr_id == ID_SPECIAL_C;

   assign ns_os = i_cur_level == EOIH_EL1
                  && (i_nonsecure_state_bit || !MONITOR_PRESENT);

   // ----------------------------------------------------------------
   // Trap decision
   // ----------------------------------------------------------------
   logic       next_trap;
   logic [1:0] next_trap_level;
   logic       mon_route;
   logic       hyp_route;
   logic       trap_all;

   assign mon_route = hit_g0 ? i_monitor_fast_irq_routing
                             : i_monitor_normal_irq_routing;
   assign hyp_route = hit_g0 ? i_hypervisor_fast_irq_routing
                             : i_hypervisor_normal_irq_routing;
   assign trap_all  = hit_g0 ? i_trap_all_group0 : i_trap_all_group1;

   always_comb begin
      next_trap       = 1'b0;
      next_trap_level = EOIH_EL1;
      if (hit) begin
         case (i_cur_level)
            EOIH_EL1: begin
               if (!i_os_sysreg_enable) begin
                  next_trap       = 1'b1;
                  next_trap_level = EOIH_EL1;
               end else if (ns_os && trap_all) begin
                  next_trap       = 1'b1;
                  next_trap_level = EOIH_EL2;
               end else if (MONITOR_PRESENT && mon_route
                            && !i_nonsecure_state_bit) begin
                  next_trap       = 1'b1;
                  next_trap_level = EOIH_EL3;
               end else if (MONITOR_PRESENT && mon_route
                            && !hyp_route) begin
                  next_trap       = 1'b1;
                  next_trap_level = EOIH_EL3;
               end
            end
            EOIH_EL2: begin
               if (!i_hypervisor_sysreg_enable) begin
                  next_trap       = 1'b1;
                  next_trap_level = EOIH_EL2;
               end else if (MONITOR_PRESENT && mon_route) begin
                  next_trap       = 1'b1;
                  next_trap_level = EOIH_EL3;
               end
            end
            EOIH_EL3: begin
               if (!i_monitor_sysreg_enable) begin
                  next_trap       = 1'b1;
                  next_trap_level = EOIH_EL3;
               end
            end
            default: begin
               next_trap       = 1'b0;
               next_trap_level = EOIH_EL1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Redirection and completion mode
   // ----------------------------------------------------------------
   logic redirect;
   logic mode;

   assign redirect = hit && !next_trap && ns_os && hyp_route;

   always_comb begin
      if (!MONITOR_PRESENT) begin
         mode = i_os_completion_mode;
      end else if (i_cur_level == EOIH_EL3) begin
         mode = i_monitor_completion_mode;
      end else if (!i_nonsecure_state_bit) begin
         mode = i_secure_os_completion_mode;
      end else begin
         mode = i_nonsecure_os_completion_mode;
      end
   end

   logic do_complete;
   assign do_complete = hit && !next_trap && !redirect
                        && !is_special;

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_prio_drop            <= 1'b0;
         o_deactivate           <= 1'b0;
         o_group1               <= 1'b0;
         o_interrupt_identifier <= 24'h000000;
      end else begin
         o_prio_drop  <= do_complete;
         o_deactivate <= do_complete && !mode;
         if (do_complete) begin
            o_group1               <= hit_g1;
            o_interrupt_identifier <= wr_id;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_virt_valid      <= 1'b0;
         o_virt_group1     <= 1'b0;
         o_virt_identifier <= 24'h000000;
      end else begin
         o_virt_valid <= redirect;
         if (redirect) begin
            o_virt_group1     <= hit_g1;
            o_virt_identifier <= wr_id;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_trap       <= 1'b0;
         o_trap_level <= RESET_LEVEL;
      end else begin
         o_trap <= next_trap;
         if (next_trap) begin
            o_trap_level <= next_trap_level;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_identifier_width_field <= 5'h00;
      end else begin
         o_identifier_width_field <= 5'(ID_BITS);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   chk_special_ignored: assert property (
      hit && is_special |=> !o_prio_drop && !o_deactivate)
      else $error("special identifier caused completion");

   chk_deact_needs_drop: assert property (
      o_deactivate |-> o_prio_drop)
      else $error("deactivate without priority drop");

   chk_mode0_deact: assert property (
      do_complete && !mode |=> o_deactivate)
      else $error("mode zero write did not deactivate");

   chk_mode1_nodeact: assert property (
      do_complete && mode |=> o_prio_drop && !o_deactivate)
      else $error("mode one write deactivated");

   chk_trap_no_effect: assert property (
      o_trap |-> !o_prio_drop && !o_virt_valid)
      else $error("trapped write had an effect");

   chk_sre_trap: assert property (
      hit && i_cur_level == EOIH_EL1 && !i_os_sysreg_enable
      |=> o_trap && o_trap_level == EOIH_EL1)
      else $error("disabled sysreg access not trapped");

   chk_virt_redirect: assert property (
      hit_g0 && ns_os && !next_trap && i_hypervisor_fast_irq_routing
      |=> o_virt_valid && !o_prio_drop)
      else $error("group zero write not redirected");

   chk_hyp_mon_trap: assert property (
      hit_g0 && MONITOR_PRESENT && i_cur_level == EOIH_EL2
      && i_hypervisor_sysreg_enable && i_monitor_fast_irq_routing
      |=> o_trap && o_trap_level == EOIH_EL3)
      else $error("hypervisor write not trapped to monitor");

   chk_id_held: assert property (
      o_prio_drop |-> o_interrupt_identifier == $past(wr_id))
      else $error("completed identifier mismatch");

   chk_el0_ignored: assert property (
      (hit_g0 || hit_g1) && i_cur_level == EOIH_EL0
      |=> !o_prio_drop && !o_trap && !o_virt_valid)
      else $error("level zero write was taken");

   chk_g1_redirect: assert property (
      hit_g1 && ns_os && !next_trap && i_hypervisor_normal_irq_routing
      |=> o_virt_valid && o_virt_group1 && !o_prio_drop)
      else $error("group one write not redirected");

   chk_trap_all_g0: assert property (
      hit_g0 && ns_os && i_os_sysreg_enable && i_trap_all_group0
      |=> o_trap && o_trap_level == EOIH_EL2)
      else $error("trap-all group zero write not trapped");

   chk_trap_all_g1: assert property (
      hit_g1 && ns_os && i_os_sysreg_enable && i_trap_all_group1
      |=> o_trap && o_trap_level == EOIH_EL2)
      else $error("trap-all group one write not trapped");

   chk_sec_mon_trap: assert property (
      hit_g0 && MONITOR_PRESENT && i_cur_level == EOIH_EL1
      && !i_nonsecure_state_bit && i_os_sysreg_enable
      && i_monitor_fast_irq_routing
      |=> o_trap && o_trap_level == EOIH_EL3)
      else $error("secure write not trapped to monitor");

   chk_ns_mon_trap: assert property (
      hit_g0 && MONITOR_PRESENT && ns_os && i_os_sysreg_enable
      && !i_trap_all_group0 && i_monitor_fast_irq_routing
      && !i_hypervisor_fast_irq_routing
      |=> o_trap && o_trap_level == EOIH_EL3)
      else $error("nonsecure write not trapped to monitor");

   chk_width_field: assert property (
      $past(i_reset_n) |-> o_identifier_width_field == 5'(ID_BITS))
      else $error("identifier width field wrong");

   cov_g0_complete: cover property (hit_g0 ##1 o_deactivate);
   cov_g1_drop_only: cover property (hit_g1 && mode ##1 o_prio_drop);
   cov_trap_mon: cover property (o_trap && o_trap_level == EOIH_EL3);
   cov_virt: cover property (o_virt_valid && o_virt_group1);
   cov_trap_hyp: cover property (o_trap && o_trap_level == EOIH_EL2);

endmodule // eoih_handler

`default_nettype wire

// ===== test/eoih_pe_model.sv
// Purpose: Processing element model issuing completion register writes
// Assumes: One write at a time, strobe held for exactly one clock
// Notes:   Released lines show inverted values, never the last ones
`timescale 1ns/100ps
`default_nettype none

module eoih_pe_model
   import eoih_pkg::*;
(
   input  wire logic        i_sys_clk,
   output logic             o_wr_valid,
   output logic [2:0]       o_wr_op1,
   output logic [3:0]       o_wr_crn,
   output logic [3:0]       o_wr_crm,
   output logic [2:0]       o_wr_op2,
   output logic [31:0]      o_wr_data
);
   initial begin
      o_wr_valid = 1'b0;
      {o_wr_op1, o_wr_crn, o_wr_crm, o_wr_op2} = 14'h0;
      o_wr_data = 32'h0;
   end

   // Data carries the identifier of the latest acknowledge of the group
   task automatic write(input logic grp1, input logic [31:0] data);
      @(posedge i_sys_clk);
      o_wr_valid <= 1'b1;
      o_wr_op1   <= ENC_OP1;
      o_wr_crn   <= ENC_CRN;
      o_wr_op2   <= ENC_OP2;
      o_wr_crm   <= grp1 ? ENC_CRM_G1 : ENC_CRM_G0;
      o_wr_data  <= data;
      @(posedge i_sys_clk);
      o_wr_valid <= 1'b0;
      o_wr_op1   <= ~ENC_OP1;
      o_wr_crn   <= ~ENC_CRN;
      o_wr_op2   <= ~ENC_OP2;
      o_wr_crm   <= ~o_wr_crm;
      o_wr_data  <= ~data;
   endtask
endmodule // eoih_pe_model
`default_nettype wire

// ===== test/eoih_handler_tb.sv
// Purpose: Self-checking bench for the completion write handler
// Assumes: Default parameters, monitor level present, 24-bit identifiers
// Notes:   Expected outcome packed as drop, deactivate, redirect, trap, level
`timescale 1ns/100ps
`default_nettype none

module eoih_handler_tb;
   import eoih_pkg::*;
   localparam logic [15:0] L1 = 16'h0001, L2 = 16'h0002, L3 = 16'h0003;
   localparam logic [15:0] NS = 16'h0004, SM = 16'h0020, NSM = 16'h0040;
   localparam logic [15:0] MONM = 16'h0010, HF = 16'h0080, HN = 16'h0100;
   localparam logic [15:0] OSE = 16'h0200, HYE = 16'h0400, MOE = 16'h0800;
   localparam logic [15:0] TA0 = 16'h1000, TA1 = 16'h2000, MF = 16'h4000;
   localparam logic [15:0] MN = 16'h8000, SRE = 16'h0e00;
   logic        sys_clk = 1'b0;
   logic        reset_n;
   logic [15:0] cfg;
   logic        wr_valid, prio_drop, deactivate, group1, virt_valid;
   logic        virt_group1, trap;
   logic [2:0]  wr_op1, wr_op2;
   logic [3:0]  wr_crn, wr_crm;
   logic [31:0] wr_data;
   logic [23:0] identifier, virt_identifier;
   logic [1:0]  trap_level;
   logic [4:0]  width;
   int          error_cnt = 0, num_checks = 0, cycles = 0;

   always #4 sys_clk = ~sys_clk;

   eoih_pe_model u_eoih_pe_model (.i_sys_clk(sys_clk), .o_wr_valid(wr_valid),
      .o_wr_op1(wr_op1), .o_wr_crn(wr_crn), .o_wr_crm(wr_crm),
      .o_wr_op2(wr_op2), .o_wr_data(wr_data));

   eoih_handler u_eoih_handler (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
      .i_wr_valid(wr_valid), .i_wr_op1(wr_op1), .i_wr_crn(wr_crn),
      .i_wr_crm(wr_crm), .i_wr_op2(wr_op2), .i_wr_data(wr_data),
      .i_cur_level(cfg[1:0]), .i_nonsecure_state_bit(cfg[2]),
      .i_os_completion_mode(cfg[3]), .i_monitor_completion_mode(cfg[4]),
      .i_secure_os_completion_mode(cfg[5]),
      .i_nonsecure_os_completion_mode(cfg[6]),
      .i_hypervisor_fast_irq_routing(cfg[7]),
      .i_hypervisor_normal_irq_routing(cfg[8]),
      .i_os_sysreg_enable(cfg[9]), .i_hypervisor_sysreg_enable(cfg[10]),
      .i_monitor_sysreg_enable(cfg[11]), .i_trap_all_group0(cfg[12]),
      .i_trap_all_group1(cfg[13]), .i_monitor_fast_irq_routing(cfg[14]),
      .i_monitor_normal_irq_routing(cfg[15]), .o_prio_drop(prio_drop),
      .o_deactivate(deactivate), .o_group1(group1),
      .o_interrupt_identifier(identifier), .o_virt_valid(virt_valid),
      .o_virt_group1(virt_group1), .o_virt_identifier(virt_identifier),
      .o_trap(trap), .o_trap_level(trap_level),
      .o_identifier_width_field(width));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // One write under settings c; e = drop, deactivate, redirect, trap, level
   task automatic run(input logic [15:0] c, input logic g,
                      input logic [31:0] d, input logic [5:0] e);
      @(posedge sys_clk);
      cfg <= c;
      u_eoih_pe_model.write(g, d);
      #1;
      check({28'h0, prio_drop, deactivate, virt_valid, trap}, {28'h0, e[5:2]});
      if (e[2])
         check({30'h0, trap_level}, {30'h0, e[1:0]});
      if (e[5])
         check({7'h0, group1, identifier}, {7'h0, g, d[23:0]});
      if (e[3])
         check({7'h0, virt_group1, virt_identifier}, {7'h0, g, d[23:0]});
   endtask

   task automatic t_modes;
      logic [15:0] ctx[4] = '{L1 | NS, L1, L3, L2 | NS};
      logic [15:0] sel[4] = '{NSM, SM, MONM, NSM};
      logic [15:0] c;
      for (int j = 0; j < 16; j++) begin
         c = ctx[j / 4] | SRE | (j[1] ? sel[j / 4] : 16'h0078 & ~sel[j / 4]);
         run(c, j[0], 32'h40 + j, {1'b1, ~j[1], 4'h0});
      end
      $display("test modes done");
   endtask

   task automatic t_reset;
      @(posedge sys_clk);
      reset_n <= 1'b0;
      @(posedge sys_clk);
      #1;
      check({26'h0, prio_drop, deactivate, group1, virt_valid, virt_group1,
             trap}, 32'h0);
      check({8'h00, identifier}, 32'h0);
      check({8'h00, virt_identifier}, 32'h0);
      check({25'h0, trap_level, width}, 32'h0);
      @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      check({27'h0, width}, ID_WIDE_BITS);
      $display("test reset done");
   endtask

   task automatic t_special;
      logic [23:0] sp[3] = '{ID_SPECIAL_A, ID_SPECIAL_B, ID_SPECIAL_C};
      for (int k = 0; k < 6; k++)
         run(L1 | NS | SRE, k[0], {8'h00, sp[k / 2]}, 6'h00);
      run(L1 | NS | SRE, 1'b0, 32'hff00_03fe, 6'h30);
      run(L1 | NS | SRE, 1'b1, 32'h00ab_cdef, 6'h30);
      $display("test special done");
   endtask

   task automatic t_redirect;
      run(L1 | NS | SRE | HF, 1'b0, 32'h0000_0123, 6'h08);
      run(L1 | NS | SRE | HN, 1'b1, 32'h0000_0456, 6'h08);
      run(L1 | NS | SRE | HF, 1'b1, 32'h0000_0789, 6'h30);
      run(L1 | SRE | HF, 1'b0, 32'h0000_0321, 6'h30);
      run(L1 | NS | SRE | HN, 1'b1, {8'h00, ID_SPECIAL_C}, 6'h08);
      $display("test redirect done");
   endtask

   task automatic t_traps;
      run(L1 | NS | (SRE & ~OSE), 1'b0, 32'h0000_0011, 6'h05);
      run(L2 | NS | (SRE & ~HYE), 1'b1, 32'h0000_0012, 6'h06);
      run(L3 | (SRE & ~MOE), 1'b0, 32'h0000_0013, 6'h07);
      run(L1 | NS | SRE | TA0, 1'b0, 32'h0000_0014, 6'h06);
      run(L1 | SRE | MF, 1'b0, 32'h0000_0015, 6'h07);
      run(L2 | NS | SRE | MF, 1'b0, 32'h0000_0016, 6'h07);
      run(L1 | NS | SRE | MF, 1'b0, 32'h0000_0017, 6'h07);
      run(L1 | NS | SRE | MF | HF, 1'b0, 32'h0000_0018, 6'h08);
      run(L1 | NS | SRE | TA1, 1'b1, 32'h0000_0019, 6'h06);
      run(L2 | NS | SRE | MN, 1'b1, 32'h0000_001a, 6'h07);
      run(L1 | NS | SRE | MN, 1'b1, 32'h0000_001b, 6'h07);
      run(L1 | SRE | MN, 1'b1, 32'h0000_001c, 6'h07);
      run(L1 | NS | SRE | TA0, 1'b1, 32'h0000_001d, 6'h30);
      run(NS | SRE | MF | TA0, 1'b0, 32'h0000_001e, 6'h00);
      $display("test traps done");
   endtask

   // Cut a hang short well beyond the 140 or so cycles the run needs
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         test_done();
      end
   end

   initial begin
      reset_n = 1'b0;
      cfg = 16'h0000;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_modes();
      t_special();
      t_redirect();
      t_traps();
      t_reset();
      test_done();
   end
endmodule // eoih_handler_tb
`default_nettype wire
